// file: core/fcsm_decode.sv
`timescale 1ns/1ps
module fcsm_decode
  import fcsm_pkg::*;
(
  // Command code
  input wire logic [7:0] code_in,
  // Category
  output fcsm_cat_type cat_out
);

  // ****************************************
  // Code to category
  // ****************************************
  always_comb begin
    case (code_in)
      CMD_READ_ARRAY: cat_out = CAT_READ_ARRAY;
      CMD_PROGRAM_SETUP_A,
      CMD_PROGRAM_SETUP_B: cat_out = CAT_PROGRAM_SETUP;
      CMD_ERASE_SETUP: cat_out = CAT_ERASE_SETUP;
      CMD_CONFIRM_RESUME: cat_out = CAT_CONFIRM_RESUME;
      CMD_SUSPEND: cat_out = CAT_SUSPEND;
      CMD_READ_STATUS: cat_out = CAT_READ_STATUS;
      CMD_CLEAR_STATUS: cat_out = CAT_CLEAR_STATUS;
      CMD_READ_ID,
      CMD_READ_QUERY: cat_out = CAT_READ_ID;
      CMD_LOCK_SETUP: cat_out = CAT_LOCK_SETUP;
      CMD_OTP_SETUP: cat_out = CAT_OTP_SETUP;
      CMD_LOCK_CONFIRM,
      CMD_LOCKDOWN_CONFIRM,
      CMD_CONFIG_CONFIRM: cat_out = CAT_LOCK_CONFIRM;
      default: cat_out = CAT_OTHER;
    endcase
  end

endmodule // fcsm_decode

// file: core/fcsm_top.sv
// Operation
// - Only one partition programs or erases at once; one sequencer runs.
// - Next state depends on current state, incoming command valid and code, and op_done_in.
// - Confirm/resume: erase setup starts erase, suspends resume, ready stays ready.
// - Program within erase suspend: suspend nests, other commands keep it busy.
// - Nested program suspend holds until resume returns it to nested programming.
// - Lock setup in erase suspend without valid confirm returns with lock error.
`timescale 1ns/1ps
module fcsm_top
  import fcsm_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // Command write
  input wire fcsm_cmd_type cmd_in,
  // Write sequencer
  input wire logic op_done_in,
  output fcsm_op_type op_kind_out,
  output logic op_start_out,
  // Status
  output fcsm_state_type state_out,
  output logic modify_active_out,
  output logic suspended_out,
  output logic erase_error_out,
  output logic lock_error_out,
  output logic [PART_W-1:0] active_partition_out
);

  fcsm_regs_type r;
  fcsm_regs_type next_r;
  fcsm_cat_type cat;

  // ****************************************
  // Command decode
  // ****************************************
  fcsm_decode u_decode (
    .code_in(cmd_in.code),
    .cat_out(cat)
  );

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic cmd;
    logic set_erase_err;
    logic set_lock_err;
    cmd = cmd_in.valid;
    set_erase_err = 1'b0;
    set_lock_err = 1'b0;
    next_r = r;
    next_r.start = 1'b0;
    case (r.fsm)
      ST_READY: begin
        if (cmd) begin
          case (cat)
            CAT_PROGRAM_SETUP: next_r.fsm = ST_PGM_SETUP;
            CAT_ERASE_SETUP: next_r.fsm = ST_ERS_SETUP;
            CAT_LOCK_SETUP: next_r.fsm = ST_LOCK_SETUP;
            CAT_OTP_SETUP: next_r.fsm = ST_OTP_SETUP;
            CAT_CONFIRM_RESUME: next_r.fsm = ST_READY;
            default: next_r.fsm = ST_READY;
          endcase
        end
      end
      ST_LOCK_SETUP: begin
        if (cmd) begin
          next_r.fsm = ST_READY;
          if (cat != CAT_LOCK_CONFIRM && cat != CAT_CONFIRM_RESUME) begin
            set_lock_err = 1'b1;
          end
        end
      end
      ST_OTP_SETUP: begin
        if (cmd) begin
          next_r.fsm = ST_OTP_BUSY;
          next_r.partition = cmd_in.partition;
          next_r.start = 1'b1;
          next_r.op = OP_OTP;
        end
      end
      ST_OTP_BUSY: begin
        if (op_done_in) begin
          next_r.fsm = ST_READY;
        end
      end
      ST_PGM_SETUP: begin
        if (cmd) begin
          next_r.fsm = ST_PGM_BUSY;
          next_r.partition = cmd_in.partition;
          next_r.start = 1'b1;
          next_r.op = OP_PROGRAM;
        end
      end
      ST_PGM_BUSY: begin
        if (op_done_in) begin
          next_r.fsm = ST_READY;
        end else if (cmd && cat == CAT_SUSPEND) begin
          next_r.fsm = ST_PGM_SUSP;
        end
      end
      ST_PGM_SUSP: begin
        if (cmd && cat == CAT_CONFIRM_RESUME) begin
          next_r.fsm = ST_PGM_BUSY;
        end
      end
      ST_ERS_SETUP: begin
        if (cmd) begin
          if (cat == CAT_CONFIRM_RESUME) begin
            next_r.fsm = ST_ERS_BUSY;
            next_r.partition = cmd_in.partition;
            next_r.start = 1'b1;
            next_r.op = OP_ERASE;
          end else begin
            next_r.fsm = ST_READY;
            set_erase_err = 1'b1;
          end
        end
      end
      ST_ERS_BUSY: begin
        if (op_done_in) begin
          next_r.fsm = ST_READY;
        end else if (cmd && cat == CAT_SUSPEND) begin
          next_r.fsm = ST_ERS_SUSP;
        end
      end
      ST_ERS_SUSP: begin
        if (cmd) begin
          case (cat)
            CAT_CONFIRM_RESUME: next_r.fsm = ST_ERS_BUSY;
            CAT_PROGRAM_SETUP: next_r.fsm = ST_PES_SETUP;
            CAT_LOCK_SETUP: next_r.fsm = ST_LOCK_SETUP_ES;
            default: next_r.fsm = ST_ERS_SUSP;
          endcase
        end
      end
      ST_PES_SETUP: begin
        if (cmd) begin
          next_r.fsm = ST_PES_BUSY;
          next_r.start = 1'b1;
          next_r.op = OP_PROGRAM;
        end
      end
      ST_PES_BUSY: begin
        if (op_done_in) begin
          next_r.fsm = ST_ERS_SUSP;
        end else if (cmd && cat == CAT_SUSPEND) begin
          next_r.fsm = ST_PES_SUSP;
        end else begin
          next_r.fsm = ST_PES_BUSY;
        end
      end
      ST_PES_SUSP: begin
        if (cmd && cat == CAT_CONFIRM_RESUME) begin
          next_r.fsm = ST_PES_BUSY;
        end else begin
          next_r.fsm = ST_PES_SUSP;
        end
      end
      ST_LOCK_SETUP_ES: begin
        if (cmd) begin
          next_r.fsm = ST_ERS_SUSP;
          if (cat != CAT_LOCK_CONFIRM && cat != CAT_CONFIRM_RESUME) begin
            set_lock_err = 1'b1;
          end
        end
      end
      default: next_r.fsm = ST_READY;
    endcase

    // Sticky errors, set wins over clear
    if (cmd && cat == CAT_CLEAR_STATUS) begin
      next_r.erase_error = 1'b0;
      next_r.lock_error = 1'b0;
    end
    if (set_erase_err) begin
      next_r.erase_error = 1'b1;
    end
    if (set_lock_err) begin
      next_r.lock_error = 1'b1;
    end

    // Single array-modifying engine
    next_r.modify_active = (next_r.fsm == ST_PGM_BUSY) || (next_r.fsm == ST_ERS_BUSY) ||
                           (next_r.fsm == ST_PES_BUSY) || (next_r.fsm == ST_OTP_BUSY);
    next_r.suspended = (next_r.fsm == ST_PGM_SUSP) || (next_r.fsm == ST_ERS_SUSP) ||
                       (next_r.fsm == ST_PES_SUSP) || (next_r.fsm == ST_PES_SETUP) ||
                       (next_r.fsm == ST_LOCK_SETUP_ES);
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      r.fsm <= ST_READY;
      r.modify_active <= 1'b0;
      r.suspended <= 1'b0;
      r.erase_error <= 1'b0;
      r.lock_error <= 1'b0;
      r.partition <= PART_RESET;
      r.start <= 1'b0;
      r.op <= OP_PROGRAM;
    end else begin
      r <= next_r;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign state_out = r.fsm;
  assign modify_active_out = r.modify_active;
  assign suspended_out = r.suspended;
  assign erase_error_out = r.erase_error;
  assign lock_error_out = r.lock_error;
  assign active_partition_out = r.partition;
  assign op_start_out = r.start;
  assign op_kind_out = r.op;

endmodule // fcsm_top

// file: inc/fcsm_pkg.sv
package fcsm_pkg;

  // ****************************************
  // Command codes
  // ****************************************
  localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
  localparam logic [7:0] CMD_PROGRAM_SETUP_A = 8'h10;
  localparam logic [7:0] CMD_PROGRAM_SETUP_B = 8'h40;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
  localparam logic [7:0] CMD_CONFIRM_RESUME = 8'hD0;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_READ_ID = 8'h90;
  localparam logic [7:0] CMD_READ_QUERY = 8'h98;
  localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
  localparam logic [7:0] CMD_OTP_SETUP = 8'hC0;
  localparam logic [7:0] CMD_LOCK_CONFIRM = 8'h01;
  localparam logic [7:0] CMD_LOCKDOWN_CONFIRM = 8'h2F;
  localparam logic [7:0] CMD_CONFIG_CONFIRM = 8'h03;

  // ****************************************
  // Widths and reset values
  // ****************************************
  localparam int PART_W = 4;
  localparam logic [PART_W-1:0] PART_RESET = 4'h0;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [3:0] {
    CAT_READ_ARRAY,
    CAT_PROGRAM_SETUP,
    CAT_ERASE_SETUP,
    CAT_CONFIRM_RESUME,
    CAT_SUSPEND,
    CAT_READ_STATUS,
    CAT_CLEAR_STATUS,
    CAT_READ_ID,
    CAT_LOCK_SETUP,
    CAT_OTP_SETUP,
    CAT_LOCK_CONFIRM,
    CAT_OTHER
  } fcsm_cat_type;

  typedef enum logic [3:0] {
    ST_READY,
    ST_LOCK_SETUP,
    ST_OTP_SETUP,
    ST_OTP_BUSY,
    ST_PGM_SETUP,
    ST_PGM_BUSY,
    ST_PGM_SUSP,
    ST_ERS_SETUP,
    ST_ERS_BUSY,
    ST_ERS_SUSP,
    ST_PES_SETUP,
    ST_PES_BUSY,
    ST_PES_SUSP,
    ST_LOCK_SETUP_ES
  } fcsm_state_type;

  typedef enum logic [1:0] {
    OP_PROGRAM,
    OP_ERASE,
    OP_OTP
  } fcsm_op_type;

  typedef struct packed {
    logic valid;
    logic [7:0] code;
    logic [PART_W-1:0] partition;
  } fcsm_cmd_type;

  typedef struct packed {
    fcsm_state_type fsm;
    logic modify_active;
    logic suspended;
    logic erase_error;
    logic lock_error;
    logic [PART_W-1:0] partition;
    logic start;
    fcsm_op_type op;
  } fcsm_regs_type;

endpackage

// file: test/fcsm_monitor.sv
`timescale 1ns/1ps
module fcsm_monitor
  import fcsm_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // Command and sequencer
  input wire fcsm_cmd_type cmd_in,
  input wire logic op_done_in,
  input wire fcsm_op_type op_kind_out,
  input wire logic op_start_out,
  // Status
  input wire fcsm_state_type state_out,
  input wire logic modify_active_out,
  input wire logic suspended_out,
  input wire logic erase_error_out,
  input wire logic lock_error_out,
  input wire logic [PART_W-1:0] active_partition_out
);
  // ****
  // Checks
  // ****
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  logic wr;
  logic [7:0] c;
  assign wr = cmd_in.valid;
  assign c = cmd_in.code;
  chk_one_modify: assert property (modify_active_out == (state_out inside
    {ST_PGM_BUSY, ST_ERS_BUSY, ST_PES_BUSY, ST_OTP_BUSY})) else $error("modify flag wrong");
  chk_idle_hold: assert property (!wr && !op_done_in |=> $stable(state_out))
    else $error("state moved without cause");
  chk_erase_go: assert property (state_out == ST_ERS_SETUP && wr && c == 8'hD0
    |=> state_out == ST_ERS_BUSY && op_start_out && op_kind_out == OP_ERASE)
    else $error("erase confirm failed");
  chk_ready_resume: assert property (state_out == ST_READY && wr && c == 8'hD0
    |=> state_out == ST_READY) else $error("resume left ready");
  chk_nest_susp: assert property (state_out == ST_PES_BUSY && wr && !op_done_in
    |=> state_out == ((c == 8'hB0) ? ST_PES_SUSP : ST_PES_BUSY)) else $error("nested busy");
  chk_nest_resume: assert property (state_out == ST_PES_SUSP && wr
    |=> state_out == ((c == 8'hD0) ? ST_PES_BUSY : ST_PES_SUSP)) else $error("nested susp");
  chk_lock_fail: assert property (state_out == ST_LOCK_SETUP_ES && wr
    && !(c inside {8'h01, 8'h2F, 8'h03, 8'hD0}) |=> state_out == ST_ERS_SUSP && lock_error_out)
    else $error("lock error missing");
  chk_erase_bad: assert property (state_out == ST_ERS_SETUP && wr && c != 8'hD0
    |=> state_out == ST_READY && erase_error_out) else $error("erase error missing");
  chk_pgm_susp: assert property (state_out == ST_PGM_BUSY && wr && c == 8'hB0
    && !op_done_in |=> state_out == ST_PGM_SUSP && suspended_out) else $error("no suspend");
  chk_no_overlap: assert property (op_start_out |-> !$past(modify_active_out))
    else $error("operation started over a running one");
endmodule // fcsm_monitor

bind fcsm_top fcsm_monitor mon (.clk_in(clk_in), .reset_in(reset_in), .cmd_in(cmd_in),
  .op_done_in(op_done_in), .op_kind_out(op_kind_out), .op_start_out(op_start_out),
  .state_out(state_out), .modify_active_out(modify_active_out),
  .suspended_out(suspended_out), .erase_error_out(erase_error_out),
  .lock_error_out(lock_error_out), .active_partition_out(active_partition_out));

// file: test/fcsm_seq_model.sv
`timescale 1ns/1ps
module fcsm_seq_model (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // Sequencer control
  input wire logic op_start_in,
  input wire logic busy_in,
  input wire logic [7:0] latency_in,
  output logic op_done_out
);
  // ****
  // Operation timer, paused while suspended
  // ****
  logic [7:0] count;
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      count <= 8'h00;
      op_done_out <= 1'b0;
    end else begin
      if (op_start_in || (busy_in && count == 8'h00)) begin
        count <= latency_in;
      end else if (busy_in) begin
        count <= count - 8'h01;
      end
      op_done_out <= busy_in && !op_start_in && count == 8'h01;
    end
  end
endmodule // fcsm_seq_model

// file: test/fcsm_top_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_errors++; \
  $display("MISMATCH %0t got %h exp %h", $time, a, b); end end
module fcsm_top_tb;
  import fcsm_pkg::*;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  fcsm_cmd_type cmd_in = '0;
  logic done;
  logic start;
  logic mod_act;
  logic e_err;
  logic l_err;
  logic susp;
  fcsm_op_type kind;
  fcsm_state_type st;
  logic [PART_W-1:0] part;
  int n_errors = 0;
  int checks = 0;
  always #4 clk_in = ~clk_in;
  fcsm_top dut (.clk_in(clk_in), .reset_in(reset_in), .cmd_in(cmd_in), .op_done_in(done),
    .op_kind_out(kind), .op_start_out(start), .state_out(st), .modify_active_out(mod_act),
    .suspended_out(susp), .erase_error_out(e_err), .lock_error_out(l_err),
    .active_partition_out(part));
  fcsm_seq_model seq (.clk_in(clk_in), .reset_in(reset_in), .op_start_in(start),
    .busy_in(mod_act), .latency_in(8'h28), .op_done_out(done));
  // ****
  // Helpers
  // ****
  task wr(input logic [7:0] c, input logic [3:0] p);
    @(negedge clk_in);
    cmd_in = {1'b1, c, p};
    @(negedge clk_in);
    cmd_in.valid = 1'b0;
  endtask
  task wait_st(input fcsm_state_type s);
    for (int i = 0; i < 200 && st !== s; i++) @(negedge clk_in);
    `CHK(st, s)
  endtask
  task report_and_stop;
    $display("n_errors=%0d checks=%0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ****
  // Scenarios
  // ****
  task t_program;
    wr(CMD_PROGRAM_SETUP_B, 4'h3); `CHK(st, ST_PGM_SETUP)
    wr(8'h12, 4'h3); `CHK({st, start, kind}, {ST_PGM_BUSY, 1'b1, OP_PROGRAM})
    `CHK(part, 4'h3)
    wr(CMD_SUSPEND, 4'h0); `CHK({st, susp}, {ST_PGM_SUSP, 1'b1})
    wr(CMD_READ_STATUS, 4'h0); `CHK(st, ST_PGM_SUSP)
    wr(CMD_CONFIRM_RESUME, 4'h0); `CHK({st, susp}, {ST_PGM_BUSY, 1'b0})
    wait_st(ST_READY);
  endtask
  task t_erase_err;
    wr(CMD_ERASE_SETUP, 4'h0); `CHK(st, ST_ERS_SETUP)
    wr(CMD_CLEAR_STATUS, 4'h0); `CHK({st, e_err}, {ST_READY, 1'b1})
    wr(CMD_CONFIRM_RESUME, 4'h0); `CHK(st, ST_READY)
    wr(CMD_CLEAR_STATUS, 4'h0); `CHK(e_err, 1'b0)
  endtask
  task t_nested;
    wr(CMD_ERASE_SETUP, 4'h0);
    wr(CMD_CONFIRM_RESUME, 4'h5); `CHK({st, start, kind}, {ST_ERS_BUSY, 1'b1, OP_ERASE})
    wr(CMD_SUSPEND, 4'h0); `CHK(st, ST_ERS_SUSP)
    wr(CMD_PROGRAM_SETUP_A, 4'h9); `CHK({st, susp}, {ST_PES_SETUP, 1'b1})
    wr(8'h34, 4'h9); `CHK({st, part}, {ST_PES_BUSY, 4'h5})
    wr(CMD_READ_ARRAY, 4'h0); `CHK(st, ST_PES_BUSY)
    wr(CMD_SUSPEND, 4'h0); `CHK(st, ST_PES_SUSP)
    wr(CMD_READ_STATUS, 4'h0); `CHK(st, ST_PES_SUSP)
    wr(CMD_CONFIRM_RESUME, 4'h0); `CHK(st, ST_PES_BUSY)
    wait_st(ST_ERS_SUSP);
    wr(CMD_LOCK_SETUP, 4'h0); `CHK(st, ST_LOCK_SETUP_ES)
    wr(CMD_READ_ARRAY, 4'h0); `CHK({st, l_err}, {ST_ERS_SUSP, 1'b1})
    wr(CMD_CLEAR_STATUS, 4'h0);
    wr(CMD_LOCK_SETUP, 4'h0);
    wr(CMD_LOCK_CONFIRM, 4'h0); `CHK({st, l_err}, {ST_ERS_SUSP, 1'b0})
    wr(CMD_CONFIRM_RESUME, 4'h0); `CHK(st, ST_ERS_BUSY)
    wait_st(ST_READY);
  endtask
  task t_lock_otp;
    wr(CMD_LOCK_SETUP, 4'h0); `CHK(st, ST_LOCK_SETUP)
    wr(CMD_LOCKDOWN_CONFIRM, 4'h0); `CHK({st, l_err}, {ST_READY, 1'b0})
    wr(CMD_LOCK_SETUP, 4'h0);
    wr(CMD_READ_QUERY, 4'h0); `CHK({st, l_err}, {ST_READY, 1'b1})
    wr(CMD_OTP_SETUP, 4'h0); `CHK({st, l_err}, {ST_OTP_SETUP, 1'b1})
    wr(8'h56, 4'h7); `CHK({st, start, kind}, {ST_OTP_BUSY, 1'b1, OP_OTP})
    `CHK({part, mod_act}, {4'h7, 1'b1})
    wr(CMD_ERASE_SETUP, 4'h0); `CHK(st, ST_OTP_BUSY)
    wait_st(ST_READY);
    `CHK({mod_act, l_err}, {1'b0, 1'b1})
  endtask
  task t_reset;
    wr(CMD_ERASE_SETUP, 4'h0);
    wr(CMD_CONFIRM_RESUME, 4'hA); `CHK({st, mod_act, part}, {ST_ERS_BUSY, 1'b1, 4'hA})
    @(negedge clk_in);
    reset_in = 1'b1;
    repeat (2) @(negedge clk_in);
    reset_in = 1'b0;
    `CHK({st, mod_act, start, part}, {ST_READY, 1'b0, 1'b0, PART_RESET})
    `CHK({l_err, e_err, susp}, {1'b0, 1'b0, 1'b0})
    wr(CMD_ERASE_SETUP, 4'h0); `CHK(st, ST_ERS_SETUP)
    wr(CMD_CONFIRM_RESUME, 4'h2); `CHK({st, part}, {ST_ERS_BUSY, 4'h2})
    wait_st(ST_READY);
  endtask
  initial begin
    repeat (20) @(negedge clk_in);
    reset_in = 1'b0;
    t_program;
    t_erase_err;
    t_nested;
    t_lock_otp;
    t_reset;
    report_and_stop;
  end
  initial begin
    #40000;
    $display("MISMATCH %0t watchdog expired", $time);
    n_errors++;
    report_and_stop;
  end
endmodule // fcsm_top_tb
